// [motor_defines.svh]
// constants of the motor speed command generator
// assumes a 20 MHz clock and a 625 kHz width count rate
//
// Functional notes
// - profile: wait 3 s, then run 1000 rpm
// - profile: 2000 rpm ten seconds later
// - profile: 3000 rpm, then stop after 10 s
// - profile: clear counter 1 s later, repeat
// - profile counter advances on 1 ms tick
// - 100% duty stops drive, 0% gives 3000 rpm
// - capture both edges, classify by level
// - low width: falling to next rising
// - on falling with both widths, new duty
// - no edge within timeout: static duty
// - timeout restarts per edge, idles after expiry
// - widths counted at divided count rate
// - input periods 1 ms to 100 ms supported
// - open-loop after init, two loop states
// - rotation starts in run and open-loop
// - closed-loop once speed reaches threshold
// - stop or error forces open-loop
// - ramp id/iq; speed ramps after id done
// - hold speed during closed-loop settling
// - closed-loop: id to zero, iq by feedback
// - pulse from carrier versus voltage compare
// - sequence state re-evaluated every ms
`ifndef MOTOR_DEFINES_SVH
`define MOTOR_DEFINES_SVH

`define CLK_HZ         20000000
`define COUNT_HZ       625000
`define COUNT_DIV      (`CLK_HZ / `COUNT_HZ)
`define TIMEOUT_MS     100
`define TIMEOUT_COUNTS (`COUNT_HZ / 1000 * `TIMEOUT_MS)
`define MS_CYCLES      (`CLK_HZ / 1000)

`define PROF_START_MS  3000
`define PROF_STEP_MS   10000
`define PROF_PAUSE_MS  1000
`define RPM_STEP1      12'h3E8
`define RPM_STEP2      12'h7D0
`define RPM_MAX        12'hBB8

`endif

// [motor_pkg.sv]
// types shared by the motor speed command generator
// assumes nothing of its surroundings
package motor_pkg;

  typedef enum logic [1:0] {
    sequence_stop_state,
    sequence_run_state,
    sequence_error_state
  } seq_state_t;

  typedef enum logic {
    open_loop_state,
    closed_loop_state
  } loop_state_t;

  typedef struct packed {
    logic signed [15:0] id;
    logic signed [15:0] iq;
  } dq_cmd_t;

endpackage

// [pwm_width_meter.sv]
// duty measurement of the filtered speed command input
// assumes a synchronised level and a count enable pulse
`timescale 1ns/1ps
`include "motor_defines.svh"

module pwm_width_meter #(
  parameter int TIMEOUT_COUNTS = `TIMEOUT_COUNTS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        count_en_in,
  input  wire logic        level_in,
  output logic      [11:0] rpm_out,
  output logic             timeout_out
);

  logic        level_q;
  logic [16:0] wcnt;
  logic [16:0] low_w;
  logic        have_low;
  logic        have_high;
  logic [16:0] tcnt;
  logic        t_run;
  logic        edge_seen;
  logic        rising;
  logic [28:0] num;
  logic [28:0] den;

  assign edge_seen = level_in != level_q;
  assign rising    = edge_seen && level_in;
  assign num       = 29'(low_w) * 29'(`RPM_MAX);
  assign den       = 29'(wcnt) + 29'(low_w);

  // ----------------------------------------
  // width capture
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level_q   <= 1'b0;
      wcnt      <= 17'h00000;
      low_w     <= 17'h00000;
      have_low  <= 1'b0;
      have_high <= 1'b0;
    end else begin
      level_q <= level_in;
      if (edge_seen) begin
        wcnt <= 17'h00000;
        if (rising) begin
          low_w    <= wcnt;
          have_low <= have_high;
        end else begin
          have_high <= 1'b1;
        end
      end else if (!t_run) begin
        have_low  <= 1'b0;
        have_high <= 1'b0;
      end else if (count_en_in && wcnt != 17'h1FFFF) begin
        wcnt <= wcnt + 17'h00001;
      end
    end
  end

  // ----------------------------------------
  // duty to speed and timeout
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tcnt        <= 17'h00000;
      t_run       <= 1'b1;
      rpm_out     <= 12'h000;
      timeout_out <= 1'b0;
    end else begin
      if (edge_seen) begin
        tcnt        <= 17'h00000;
        t_run       <= 1'b1;
        timeout_out <= 1'b0;
        if (!rising && have_low && den != 29'h0) begin
          rpm_out <= 12'(num / den);
        end
      end else if (t_run && count_en_in) begin
        if (tcnt == 17'(TIMEOUT_COUNTS - 1)) begin
          t_run       <= 1'b0;
          timeout_out <= 1'b1;
          rpm_out     <= level_in ? 12'h000 : `RPM_MAX;
        end else begin
          tcnt <= tcnt + 17'h00001;
        end
      end
    end
  end

  a_timeout_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !t_run && !edge_seen |=> !t_run && tcnt == $past(tcnt))
    else $error("timeout counter restarted without an edge");

  a_static_rpm: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(timeout_out) |-> rpm_out == (level_q ? 12'h000 : `RPM_MAX))
    else $error("static duty speed wrong");

  a_rise_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
    rising |=> $stable(rpm_out))
    else $error("speed changed on a rising edge");

endmodule

// [motor_speed_command_generator.sv]
// speed command, current reference mode and carrier pulses
// assumes one 20 MHz clock; speed command input is an async pin
`timescale 1ns/1ps
`include "motor_defines.svh"

module motor_speed_command_generator #(
  parameter int        MS_CYCLES      = `MS_CYCLES,
  parameter int        COUNT_DIV      = `COUNT_DIV,
  parameter int        TIMEOUT_COUNTS = `TIMEOUT_COUNTS,
  parameter logic [11:0] CLOSED_RPM   = 12'h1F4,
  parameter logic [11:0] SPEED_STEP   = 12'h002,
  parameter logic [14:0] ID_OPEN      = 15'h0400,
  parameter logic [14:0] IQ_OPEN      = 15'h0200,
  parameter logic [14:0] IQ_MAX       = 15'h1000,
  parameter logic [14:0] I_STEP       = 15'h0010,
  parameter logic [9:0]  SETTLE_MS    = 10'h064,
  parameter logic [9:0]  CARRIER_MAX  = 10'h1F4
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              speed_command_input_in,
  input  wire logic              profile_mode_in,
  input  wire logic              reverse_in,
  input  wire logic              error_request_in,
  input  wire logic              error_clear_in,
  input  wire logic       [11:0] speed_feedback_in,
  input  wire logic [2:0] [9:0]  phase_voltage_in,
  output motor_pkg::seq_state_t  sequence_state_out,
  output motor_pkg::loop_state_t loop_state_out,
  output logic            [11:0] speed_target_out,
  output logic signed     [15:0] speed_command_out,
  output motor_pkg::dq_cmd_t     dq_command_out,
  output logic                   drive_enable_out,
  output logic            [2:0]  pulse_out
);

  logic [15:0] ms_div;
  logic        ms_tick;
  logic [7:0]  cnt_div;
  logic        count_en;
  logic        sync1;
  logic        sync2;
  logic        sync3;
  logic        cmd_level;
  logic [11:0] pwm_rpm;
  logic [15:0] prof_ms;
  logic [11:0] prof_rpm;
  logic [11:0] target;
  logic        run_req;
  logic [11:0] speed_mag;
  logic [14:0] id_mag;
  logic [14:0] iq_mag;
  logic [9:0]  settle;
  logic [9:0]  carrier;
  logic        carrier_up;
  logic        running;
  motor_pkg::seq_state_t  seq;
  motor_pkg::loop_state_t loop_st;

  // ----------------------------------------
  // timebases
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ms_div  <= 16'h0000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= ms_div == 16'(MS_CYCLES - 1);
      ms_div  <= ms_div == 16'(MS_CYCLES - 1) ? 16'h0000 : ms_div + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_div  <= 8'h00;
      count_en <= 1'b0;
    end else begin
      count_en <= cnt_div == 8'(COUNT_DIV - 1);
      cnt_div  <= cnt_div == 8'(COUNT_DIV - 1) ? 8'h00 : cnt_div + 8'h01;
    end
  end

  // ----------------------------------------
  // command input synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      sync3     <= 1'b0;
      cmd_level <= 1'b0;
    end else begin
      sync1 <= speed_command_input_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        cmd_level <= sync3;
      end
    end
  end

  pwm_width_meter #(
    .TIMEOUT_COUNTS (TIMEOUT_COUNTS)
  ) u_meter (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .count_en_in (count_en),
    .level_in    (cmd_level),
    .rpm_out     (pwm_rpm),
    .timeout_out ()
  );

  // ----------------------------------------
  // timed speed profile
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prof_ms <= 16'h0000;
    end else if (ms_tick) begin
      if (prof_ms == 16'(`PROF_START_MS + 3 * `PROF_STEP_MS + `PROF_PAUSE_MS - 1)) begin
        prof_ms <= 16'h0000;
      end else begin
        prof_ms <= prof_ms + 16'h0001;
      end
    end
  end

  always_comb begin
    if (prof_ms < 16'(`PROF_START_MS)) begin
      prof_rpm = 12'h000;
    end else if (prof_ms < 16'(`PROF_START_MS + `PROF_STEP_MS)) begin
      prof_rpm = `RPM_STEP1;
    end else if (prof_ms < 16'(`PROF_START_MS + 2 * `PROF_STEP_MS)) begin
      prof_rpm = `RPM_STEP2;
    end else if (prof_ms < 16'(`PROF_START_MS + 3 * `PROF_STEP_MS)) begin
      prof_rpm = `RPM_MAX;
    end else begin
      prof_rpm = 12'h000;
    end
  end

  assign target  = profile_mode_in ? prof_rpm : pwm_rpm;
  assign run_req = target != 12'h000;
  assign running = seq == motor_pkg::sequence_run_state;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      speed_target_out <= 12'h000;
      drive_enable_out <= 1'b0;
    end else begin
      speed_target_out <= target;
      drive_enable_out <= running;
    end
  end

  // ----------------------------------------
  // system sequence
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seq <= motor_pkg::sequence_stop_state;
    end else if (ms_tick) begin
      case (seq)
        motor_pkg::sequence_stop_state: begin
          if (error_request_in) begin
            seq <= motor_pkg::sequence_error_state;
          end else if (run_req) begin
            seq <= motor_pkg::sequence_run_state;
          end
        end
        motor_pkg::sequence_run_state: begin
          if (error_request_in) begin
            seq <= motor_pkg::sequence_error_state;
          end else if (!run_req) begin
            seq <= motor_pkg::sequence_stop_state;
          end
        end
        default: begin
          if (error_clear_in && !error_request_in) begin
            seq <= motor_pkg::sequence_stop_state;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // current reference mode
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      loop_st <= motor_pkg::open_loop_state;
    end else if (!running) begin
      loop_st <= motor_pkg::open_loop_state;
    end else if (loop_st == motor_pkg::open_loop_state && speed_mag >= CLOSED_RPM) begin
      loop_st <= motor_pkg::closed_loop_state;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      settle <= 10'h000;
    end else if (loop_st == motor_pkg::open_loop_state) begin
      settle <= SETTLE_MS;
    end else if (ms_tick && settle != 10'h000) begin
      settle <= settle - 10'h001;
    end
  end

  // ----------------------------------------
  // speed and current ramps
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      speed_mag <= 12'h000;
    end else if (!running) begin
      speed_mag <= 12'h000;
    end else if (ms_tick) begin
      if ((loop_st == motor_pkg::open_loop_state && id_mag == ID_OPEN) ||
          (loop_st == motor_pkg::closed_loop_state && settle == 10'h000)) begin
        if (speed_mag + SPEED_STEP <= target) begin
          speed_mag <= speed_mag + SPEED_STEP;
        end else if (speed_mag >= target + SPEED_STEP) begin
          speed_mag <= speed_mag - SPEED_STEP;
        end else begin
          speed_mag <= target;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      id_mag <= 15'h0000;
    end else if (!running) begin
      id_mag <= 15'h0000;
    end else if (ms_tick) begin
      if (loop_st == motor_pkg::open_loop_state) begin
        id_mag <= (id_mag + I_STEP >= ID_OPEN) ? ID_OPEN : id_mag + I_STEP;
      end else begin
        id_mag <= (id_mag <= I_STEP) ? 15'h0000 : id_mag - I_STEP;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      iq_mag <= 15'h0000;
    end else if (!running) begin
      iq_mag <= 15'h0000;
    end else if (ms_tick) begin
      if (loop_st == motor_pkg::open_loop_state) begin
        iq_mag <= (iq_mag + I_STEP >= IQ_OPEN) ? IQ_OPEN : iq_mag + I_STEP;
      end else if (speed_feedback_in < speed_mag && iq_mag + I_STEP <= IQ_MAX) begin
        iq_mag <= iq_mag + I_STEP;
      end else if (speed_feedback_in > speed_mag && iq_mag >= I_STEP) begin
        iq_mag <= iq_mag - I_STEP;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      speed_command_out <= 16'sh0000;
      dq_command_out    <= '0;
    end else begin
      speed_command_out <= reverse_in ? -$signed({4'h0, speed_mag})
                                      : $signed({4'h0, speed_mag});
      dq_command_out.id <= reverse_in ? -$signed({1'b0, id_mag}) : $signed({1'b0, id_mag});
      dq_command_out.iq <= reverse_in ? -$signed({1'b0, iq_mag}) : $signed({1'b0, iq_mag});
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sequence_state_out <= motor_pkg::sequence_stop_state;
      loop_state_out     <= motor_pkg::open_loop_state;
    end else begin
      sequence_state_out <= seq;
      loop_state_out     <= loop_st;
    end
  end

  // ----------------------------------------
  // triangular carrier and pulses
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      carrier    <= 10'h000;
      carrier_up <= 1'b1;
    end else if (carrier_up) begin
      carrier    <= carrier + 10'h001;
      carrier_up <= carrier + 10'h001 != CARRIER_MAX;
    end else begin
      carrier    <= carrier - 10'h001;
      carrier_up <= carrier == 10'h001;
    end
  end

  for (genvar p = 0; p < 3; p++) begin : g_phase
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        pulse_out[p] <= 1'b0;
      end else begin
        pulse_out[p] <= running && phase_voltage_in[p] > carrier;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_open_on_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    !running |=> loop_st == motor_pkg::open_loop_state)
    else $error("closed loop held outside run");

  a_closed_entry: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(loop_st == motor_pkg::closed_loop_state) |->
      $past(running) && $past(speed_mag) >= CLOSED_RPM)
    else $error("closed loop entered below threshold");

  a_seq_on_tick: assert property (@(posedge clk_in) disable iff (rst_in)
    !$past(ms_tick) |-> $stable(seq))
    else $error("sequence changed between ticks");

  a_profile_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
    ms_tick && prof_ms == 16'(`PROF_START_MS + 3 * `PROF_STEP_MS + `PROF_PAUSE_MS - 1)
      |=> prof_ms == 16'h0000)
    else $error("profile counter did not wrap");

  a_profile_first: assert property (@(posedge clk_in) disable iff (rst_in)
    prof_ms == 16'(`PROF_START_MS) |-> prof_rpm == `RPM_STEP1)
    else $error("first profile step wrong");

  a_settle_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    running && loop_st == motor_pkg::closed_loop_state && settle != 10'h000
      |=> $stable(speed_mag))
    else $error("speed moved during settling");

  a_speed_after_id: assert property (@(posedge clk_in) disable iff (rst_in)
    running && loop_st == motor_pkg::open_loop_state && id_mag != ID_OPEN
      && $past(running) |=> $stable(speed_mag))
    else $error("speed ramped before d current settled");

  a_pulse_compare: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 pulse_out[0] == ($past(running) && $past(phase_voltage_in[0]) > $past(carrier)))
    else $error("pulse does not follow carrier compare");

endmodule

// [pwm_command_source.sv]
// external controller model driving the speed command pin
// assumes the bench sets widths in clock cycles and holds them per test
`timescale 1ns/1ps

module pwm_command_source (
  input  wire logic        clk_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic [15:0] high_in,
  input  wire logic [15:0] low_in,
  output logic             pin_out
);
  logic [15:0] count;

  // ----------------------------------------
  // static level or free running pulse train
  // ----------------------------------------
  initial begin
    pin_out = 1'b0;
    count = 16'h0000;
  end

  always @(posedge clk_in) begin
    if (mode_in != 2'h2) begin
      pin_out <= mode_in[0];
      count   <= 16'h0000;
    end else if (count == 16'h0000) begin
      pin_out <= ~pin_out;
      count   <= (pin_out ? low_in : high_in) - 16'h0001;
    end else begin
      count <= count - 16'h0001;
    end
  end
endmodule

// [motor_speed_command_generator_test.sv]
// self-checking bench of the motor speed command generator
// assumes shortened ms tick, count divider and timeout parameters
`timescale 1ns/1ps

module motor_speed_command_generator_test;
  localparam int MS  = 1;
  localparam int DIV = 2;
  localparam int TMO = 2000;
  localparam int TOL = 12;

  logic                   clk_in = 1'b0;
  logic                   rst_in = 1'b1;
  logic                   profile_mode_in = 1'b1;
  logic                   reverse_in = 1'b0;
  logic                   error_request_in = 1'b0;
  logic                   error_clear_in = 1'b0;
  logic [11:0]            speed_feedback_in = 12'h000;
  logic [2:0] [9:0]       phase_voltage_in = {10'h3FF, 10'h000, 10'h000};
  logic                   pin;
  logic [1:0]             src_mode = 2'h0;
  logic [15:0]            src_high = 16'h0100;
  logic [15:0]            src_low = 16'h0100;
  motor_pkg::seq_state_t  sequence_state_out;
  motor_pkg::loop_state_t loop_state_out;
  logic [11:0]            speed_target_out;
  logic signed [15:0]     speed_command_out;
  motor_pkg::dq_cmd_t     dq_command_out;
  logic                   drive_enable_out;
  logic [2:0]             pulse_out;
  int                     mismatches = 0;
  int                     n_tests = 0;
  int                     cyc = 0;
  int                     total;
  int                     low;
  logic signed [15:0]     held;
  int                     prof_ms [5] = '{3000, 13000, 23000, 33000, 37000};
  logic [11:0]            prof_rpm [5] = '{12'h3E8, 12'h7D0, 12'hBB8, 12'h000, 12'h3E8};

  motor_speed_command_generator #(
    .MS_CYCLES      (MS),
    .COUNT_DIV      (DIV),
    .TIMEOUT_COUNTS (TMO)
  ) i_motor_speed_command_generator (
    .clk_in                 (clk_in),
    .rst_in                 (rst_in),
    .speed_command_input_in (pin),
    .profile_mode_in        (profile_mode_in),
    .reverse_in             (reverse_in),
    .error_request_in       (error_request_in),
    .error_clear_in         (error_clear_in),
    .speed_feedback_in      (speed_feedback_in),
    .phase_voltage_in       (phase_voltage_in),
    .sequence_state_out     (sequence_state_out),
    .loop_state_out         (loop_state_out),
    .speed_target_out       (speed_target_out),
    .speed_command_out      (speed_command_out),
    .dq_command_out         (dq_command_out),
    .drive_enable_out       (drive_enable_out),
    .pulse_out              (pulse_out)
  );

  pwm_command_source i_pwm_command_source (
    .clk_in  (clk_in),
    .mode_in (src_mode),
    .high_in (src_high),
    .low_in  (src_low),
    .pin_out (pin)
  );

  // ----------------------------------------
  // clock, cycle count, helpers
  // ----------------------------------------
  initial begin
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc <= rst_in ? 0 : cyc + 1;
    speed_feedback_in <= 12'($urandom % 4096);
    phase_voltage_in[0] <= 10'($urandom % 1024);
  end

  function automatic logic [11:0] exp_rpm(int high, int lw);
    return 12'(lw * 3000 / (high + lw));
  endfunction

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_near(string what, logic [11:0] exp, logic [11:0] got);
    int d;
    n_tests++;
    d = int'(got) - int'(exp);
    if ($isunknown(got) || d > TOL || d < -TOL) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic at_ms(int ms);
    while (cyc < ms * MS) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic do_reset(logic prof);
    @(posedge clk_in);
    rst_in <= 1'b1;
    profile_mode_in <= prof;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_in);
    mismatches++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(63));
    do_reset(1'b1);
    @(negedge clk_in);
    chk("loop", 16'(motor_pkg::open_loop_state), 16'(loop_state_out));
    for (int i = 0; i < 5; i++) begin
      at_ms(prof_ms[i] - 3);
      chk("target", {4'h0, (i == 0) ? 12'h000 : prof_rpm[i - 1]},
          {4'h0, speed_target_out});
      at_ms(prof_ms[i] + 3);
      chk("target", {4'h0, prof_rpm[i]}, {4'h0, speed_target_out});
      if (i == 0) begin
        at_ms(prof_ms[0] + 10);
        chk("seq", 16'(motor_pkg::sequence_run_state), 16'(sequence_state_out));
        chk("loop", 16'(motor_pkg::open_loop_state), 16'(loop_state_out));
        chk("pulse", 16'h0004, {13'h0000, pulse_out[2:1], 1'b0});
        for (int k = 0; k < 1000 * MS && loop_state_out !== motor_pkg::closed_loop_state; k++)
          @(negedge clk_in);
        chk("loop", 16'(motor_pkg::closed_loop_state), 16'(loop_state_out));
        chk("id", 16'h0400, dq_command_out.id);
        held = speed_command_out;
        repeat (50 * MS) @(negedge clk_in);
        chk("speed", held, speed_command_out);
        at_ms(5000);
        chk("id", 16'h0000, dq_command_out.id);
      end
      if (i == 3) begin
        at_ms(prof_ms[3] + 10);
        chk("seq", 16'(motor_pkg::sequence_stop_state), 16'(sequence_state_out));
        chk("loop", 16'(motor_pkg::open_loop_state), 16'(loop_state_out));
        chk("drive", 16'h0000, {15'h0000, drive_enable_out});
      end
    end
    @(posedge clk_in);
    reverse_in <= 1'b1;
    src_mode <= 2'h0;
    do_reset(1'b0);
    repeat (TMO * DIV + 200) @(posedge clk_in);
    @(negedge clk_in);
    chk("target", 16'h0BB8, {4'h0, speed_target_out});
    repeat (30 * MS) @(negedge clk_in);
    chk("seq", 16'(motor_pkg::sequence_run_state), 16'(sequence_state_out));
    chk("id sign", 16'h0001, {15'h0000, dq_command_out.id[15]});
    chk("iq sign", 16'h0001, {15'h0000, dq_command_out.iq[15]});
    @(posedge clk_in);
    error_request_in <= 1'b1;
    repeat (5 * MS) @(negedge clk_in);
    chk("seq", 16'(motor_pkg::sequence_error_state), 16'(sequence_state_out));
    chk("loop", 16'(motor_pkg::open_loop_state), 16'(loop_state_out));
    chk("drive", 16'h0000, {15'h0000, drive_enable_out});
    @(posedge clk_in);
    error_request_in <= 1'b0;
    error_clear_in <= 1'b1;
    repeat (5 * MS) @(negedge clk_in);
    chk("leave", 16'h0, {15'h0, sequence_state_out == motor_pkg::sequence_error_state});
    @(posedge clk_in);
    error_clear_in <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      total = 625 + $urandom % 276;
      low = 20 + $urandom % (total - 40);
      if (i == 0) low = 20;
      if (i == 1) low = total - 20;
      @(posedge clk_in);
      src_high <= 16'((total - low) * DIV);
      src_low <= 16'(low * DIV);
      src_mode <= 2'h2;
      repeat (3 * 900 * DIV + 100) @(posedge clk_in);
      @(negedge clk_in);
      chk_near("duty rpm", exp_rpm(total - low, low),
               speed_target_out);
    end
    @(posedge clk_in);
    src_mode <= 2'h1;
    repeat (TMO * DIV + 2000) @(posedge clk_in);
    @(negedge clk_in);
    chk("target", 16'h0000, {4'h0, speed_target_out});
    repeat (10 * MS) @(negedge clk_in);
    chk("drive", 16'h0000, {15'h0000, drive_enable_out});
    stop_test();
  end
endmodule
